// [rtl/csd_regs.svh]
// Purpose: offsets, fields, reset values and divider constants
// Assumes: included by bare name
// Notes: byte offsets on a 32-bit AHB-Lite slave, one aligned word per register
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets (low eight address bits)
`define CSD_OFF_DIVISOR 8'h00
`define CSD_OFF_FEEDBACK 8'h04
`define CSD_OFF_TUNE 8'h08
`define CSD_OFF_CTRL 8'h0C
`define CSD_OFF_STATUS 8'h10

////////////////////////////////////////////////////////////////////////////////
// clock divisor register fields
`define CSD_RCPS_LSB 8
`define CSD_RCPS_MSB 10
`define CSD_POST_LSB 6
`define CSD_POST_MSB 7
`define CSD_PRE_LSB 0
`define CSD_PRE_MSB 4
// feedback divisor and tuning fields
`define CSD_FB_MSB 8
`define CSD_TUNE_MSB 5
// control register fields
`define CSD_SWREQ_BIT 0
`define CSD_NEWSEL_LSB 8
`define CSD_NEWSEL_MSB 10

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CSD_RCPS_RST 3'h0
`define CSD_POST_RST 2'h1
`define CSD_PRE_RST 5'h00
`define CSD_FB_RST 9'h000
`define CSD_TUNE_RST 6'h00

////////////////////////////////////////////////////////////////////////////////
// divider constants
`define CSD_DIV_W 10
`define CSD_DIV_ONE 10'h001
`define CSD_PLL_OFFSET 10'h002
`define CSD_FIXED16_DIV 10'h010
`define CSD_CY_DIV 10'h002

`endif

// [rtl/csd_pkg.sv]
// Purpose: types shared by the clock select design files
// Assumes: every use is package-qualified
// Notes: encodings of the select field follow the configuration codes
package csd_pkg;

   // oscillator selection codes, same as the initial select field
   typedef enum logic [2:0] {
      CSD_SEL_FAST_RC = 3'h0,
      CSD_SEL_FAST_RC_PLL = 3'h1,
      CSD_SEL_PRIMARY = 3'h2,
      CSD_SEL_PRIMARY_PLL = 3'h3,
      CSD_SEL_SECONDARY = 3'h4,
      CSD_SEL_SLOW_RC = 3'h5,
      CSD_SEL_FAST_RC_DIV16 = 3'h6,
      CSD_SEL_FAST_RC_POST = 3'h7
   } csd_osc_sel_e;

   // primary oscillator kind codes
   typedef enum logic [1:0] {
      CSD_PRI_EXT_CLOCK = 2'h0,
      CSD_PRI_CRYSTAL = 2'h1,
      CSD_PRI_HIGH_SPEED = 2'h2,
      CSD_PRI_OFF = 2'h3
   } csd_pri_kind_e;

   // the twelve clock modes
   typedef enum logic [3:0] {
      CSD_MODE_RC_POSTSCALE = 4'h0,
      CSD_MODE_RC_DIV16 = 4'h1,
      CSD_MODE_SLOW_RC = 4'h2,
      CSD_MODE_SECONDARY = 4'h3,
      CSD_MODE_HSPEED_PLL = 4'h4,
      CSD_MODE_CRYSTAL_PLL = 4'h5,
      CSD_MODE_EXTCLK_PLL = 4'h6,
      CSD_MODE_HSPEED = 4'h7,
      CSD_MODE_CRYSTAL = 4'h8,
      CSD_MODE_EXTCLK = 4'h9,
      CSD_MODE_RC_PLL = 4'hA,
      CSD_MODE_RC = 4'hB
   } csd_mode_e;

   // clock switch sequencer states
   typedef enum logic [1:0] {
      CSD_SW_IDLE = 2'b00,
      CSD_SW_WAIT = 2'b01
   } csd_sw_state_e;

endpackage

// [rtl/csd_div_if.sv]
// Purpose: carrier between the top and one event divider
// Assumes: single system clock
// Notes: ticks are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
`include "csd_regs.svh"
interface csd_div_if;
   logic in_tick; // input event pulse
   logic [`CSD_DIV_W-1:0] divisor; // requested division factor
   logic out_tick; // divided event pulse
   modport div (input in_tick, input divisor, output out_tick);
   modport user (output in_tick, output divisor, input out_tick);
endinterface
`default_nettype wire

// [rtl/csd_clock_divisor_reg.sv]
// Purpose: divide an event pulse stream by a programmable factor
// Assumes: divisor of zero behaves as one
// Notes: a new factor is taken only at the end of a full output period
`timescale 1ns/1ns
`default_nettype none
`include "csd_regs.svh"
module csd_clock_divisor_reg (
   input wire logic clk,
   input wire logic rst_n,
   csd_div_if.div dv
);
   logic [`CSD_DIV_W-1:0] cnt_r; // events seen in this period
   logic [`CSD_DIV_W-1:0] cnt_nxt;
   logic [`CSD_DIV_W-1:0] div_r; // factor in use this period
   logic [`CSD_DIV_W-1:0] div_nxt;
   logic [`CSD_DIV_W-1:0] load_val; // sanitised requested factor
   logic term; // last event of the period

   ////////////////////////////////////////////////////////////////////////////
   // factor latched at period end, so a change never cuts a period short
   assign load_val = (dv.divisor == '0) ? `CSD_DIV_ONE : dv.divisor;
   assign term = (cnt_r == (div_r - `CSD_DIV_ONE));
   assign dv.out_tick = dv.in_tick & term;
   assign cnt_nxt = !dv.in_tick ? cnt_r : (term ? '0 : cnt_r + `CSD_DIV_ONE);
   assign div_nxt = (dv.in_tick & term) ? load_val : div_r;

   // counter and factor state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         div_r <= `CSD_DIV_ONE;
      end else begin
         cnt_r <= cnt_nxt;
         div_r <= div_nxt;
      end
   end
endmodule // csd_clock_divisor_reg
`default_nettype wire

// [rtl/csd_top.sv]
// Purpose: system clock source select, fast RC postscaler and PLL dividers
// Assumes: oscillator and VCO outputs arrive as slow pins sampled by clk
// Notes: all derived clocks are one-cycle enable pulses on clk
//
// Overview of operation
// - fast RC postscaler up to 1:256
// - fast RC trim from tuning register
// - slow RC feeds watchdog and failsafe monitor
// - reset source from configuration select fields
// - erased configuration gives fast RC
// - fields encode twelve clock modes
// - oscillator output divided by two
// - PLL only for primary and fast RC
// - prescale factor two to 33, zero gives two
// - feedback factor from nine-bit field
// - postscale factor two, four or eight
// - output equals input times feedback over prescales
// - select and primary kind code tables
// - postscale encoding, reset default divide by four
// - fast RC postscale encoding, default divide by one
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "csd_regs.svh"
module csd_top (
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // nonvolatile configuration fields
   input wire logic [2:0] initial_osc_sel,
   input wire logic [1:0] primary_osc_kind,
   // oscillator and VCO pins
   input wire logic fast_rc_osc,
   input wire logic primary_osc,
   input wire logic secondary_osc,
   input wire logic slow_rc_osc,
   input wire logic vco_osc,
   // derived clock enables
   output logic osc_tick,
   output logic instr_tick,
   output logic peripheral_timebase_tick,
   output logic watchdog_ref_tick,
   output logic failsafe_ref_tick,
   output logic pll_ref_tick,
   output logic pll_fb_tick,
   // analog controls
   output logic pll_en,
   output logic primary_amp_en,
   output logic primary_high_gain,
   output logic [5:0] rc_tune
);

   ////////////////////////////////////////////////////////////////////////////
   // helper functions

   // fast RC postscale code to factor
   function automatic logic [`CSD_DIV_W-1:0] rc_post_div(input logic [2:0] code);
      case (code)
         3'h0: rc_post_div = 10'h001;
         3'h1: rc_post_div = 10'h002;
         3'h2: rc_post_div = 10'h004;
         3'h3: rc_post_div = 10'h008;
         3'h4: rc_post_div = 10'h010;
         3'h5: rc_post_div = 10'h020;
         3'h6: rc_post_div = 10'h040;
         default: rc_post_div = 10'h100;
      endcase
   endfunction

   // PLL postscale code to factor; the reserved code keeps divide by four
   function automatic logic [`CSD_DIV_W-1:0] pll_post_div(input logic [1:0] code);
      case (code)
         2'h0: pll_post_div = 10'h002;
         2'h3: pll_post_div = 10'h008;
         default: pll_post_div = 10'h004;
      endcase
   endfunction

   // primary select with its oscillator off falls back to fast RC
   function automatic csd_pkg::csd_osc_sel_e eff_sel(input logic [2:0] sel,
                                                     input logic [1:0] kind);
      if ((sel[2:1] == 2'b01) && (kind == csd_pkg::CSD_PRI_OFF)) begin
         eff_sel = csd_pkg::CSD_SEL_FAST_RC;
      end else begin
         eff_sel = csd_pkg::csd_osc_sel_e'(sel);
      end
   endfunction

   // select and primary kind to one of the twelve modes
   function automatic csd_pkg::csd_mode_e mode_of(input logic [2:0] sel,
                                                  input logic [1:0] kind);
      logic pll;
      pll = sel[0];
      case (sel)
         3'h7: mode_of = csd_pkg::CSD_MODE_RC_POSTSCALE;
         3'h6: mode_of = csd_pkg::CSD_MODE_RC_DIV16;
         3'h5: mode_of = csd_pkg::CSD_MODE_SLOW_RC;
         3'h4: mode_of = csd_pkg::CSD_MODE_SECONDARY;
         3'h2, 3'h3: begin
            case (kind)
               2'h2: mode_of = pll ? csd_pkg::CSD_MODE_HSPEED_PLL
                                   : csd_pkg::CSD_MODE_HSPEED;
               2'h1: mode_of = pll ? csd_pkg::CSD_MODE_CRYSTAL_PLL
                                   : csd_pkg::CSD_MODE_CRYSTAL;
               default: mode_of = pll ? csd_pkg::CSD_MODE_EXTCLK_PLL
                                      : csd_pkg::CSD_MODE_EXTCLK;
            endcase
         end
         3'h1: mode_of = csd_pkg::CSD_MODE_RC_PLL;
         default: mode_of = csd_pkg::CSD_MODE_RC;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts once stages two and
   // three agree, which also rejects a single-sample glitch
   logic [4:0] pin_s1_r; // first stage, read only by the second
   logic [4:0] pin_s2_r;
   logic [4:0] pin_s3_r;
   logic [4:0] pin_lvl_r; // accepted level
   logic [4:0] pin_lvl_nxt;
   logic [4:0] pin_rise; // rising event per pin
   logic [4:0] pin_agree;

   assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
   assign pin_lvl_nxt = (pin_agree & pin_s3_r) | (~pin_agree & pin_lvl_r);
   assign pin_rise = pin_lvl_nxt & ~pin_lvl_r;

   // synchroniser stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 5'h00;
         pin_s2_r <= 5'h00;
         pin_s3_r <= 5'h00;
         pin_lvl_r <= 5'h00;
      end else begin
         pin_s1_r <= {vco_osc, slow_rc_osc, secondary_osc, primary_osc, fast_rc_osc};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_lvl_r <= pin_lvl_nxt;
      end
   end

   logic fast_rise; // fast RC edge
   logic pri_rise; // primary edge
   logic sec_rise; // secondary edge
   logic slow_rise; // slow RC edge
   logic vco_rise; // VCO edge
   assign fast_rise = pin_rise[0];
   assign pri_rise = pin_rise[1];
   assign sec_rise = pin_rise[2];
   assign slow_rise = pin_rise[3];
   assign vco_rise = pin_rise[4];

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY
   logic dp_wr_r; // write data phase pending
   logic [7:0] dp_addr_r; // address of that write
   logic [31:0] hrdata_r; // read data captured at the address phase
   logic addr_ok; // address phase accepted
   logic wr_div; // write strobes in the data phase
   logic wr_fb;
   logic wr_tune;
   logic wr_ctrl;
   logic [31:0] rd_val;

   assign addr_ok = hsel & htrans[1] & hready;
   assign wr_div = dp_wr_r & (dp_addr_r == `CSD_OFF_DIVISOR);
   assign wr_fb = dp_wr_r & (dp_addr_r == `CSD_OFF_FEEDBACK);
   assign wr_tune = dp_wr_r & (dp_addr_r == `CSD_OFF_TUNE);
   assign wr_ctrl = dp_wr_r & (dp_addr_r == `CSD_OFF_CTRL);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // software registers and clock state
   logic [2:0] rc_postscale_sel_r; // fast RC postscale code
   logic [1:0] postscale_field_r; // PLL postscale code
   logic [4:0] prescale_field_r; // PLL prescale code
   logic [8:0] feedback_field_r; // PLL feedback code
   logic [5:0] tune_r; // fast RC trim
   logic [2:0] new_sel_r; // requested source
   logic swreq_r; // switch request pending
   logic swreq_nxt;
   logic [1:0] kind_r; // captured primary kind
   logic cap_done_r; // configuration captured
   csd_pkg::csd_osc_sel_e cur_sel_r; // source in use
   csd_pkg::csd_osc_sel_e cur_sel_nxt;
   csd_pkg::csd_sw_state_e sw_state_r;
   csd_pkg::csd_sw_state_e sw_state_nxt;
   csd_pkg::csd_mode_e cur_mode;
   logic sw_done; // switch applied this cycle
   logic pll_act; // current source uses the PLL
   logic cy_boundary; // end of an instruction period

   assign cur_mode = mode_of(cur_sel_r, kind_r);
   assign pll_act = (cur_sel_r == csd_pkg::CSD_SEL_FAST_RC_PLL) |
                    (cur_sel_r == csd_pkg::CSD_SEL_PRIMARY_PLL);

   // readback mux
   always_comb begin
      rd_val = 32'h0000_0000;
      case (haddr[7:0])
         `CSD_OFF_DIVISOR: begin
            rd_val[`CSD_RCPS_MSB:`CSD_RCPS_LSB] = rc_postscale_sel_r;
            rd_val[`CSD_POST_MSB:`CSD_POST_LSB] = postscale_field_r;
            rd_val[`CSD_PRE_MSB:`CSD_PRE_LSB] = prescale_field_r;
         end
         `CSD_OFF_FEEDBACK: rd_val[`CSD_FB_MSB:0] = feedback_field_r;
         `CSD_OFF_TUNE: rd_val[`CSD_TUNE_MSB:0] = tune_r;
         `CSD_OFF_CTRL: begin
            rd_val[`CSD_NEWSEL_MSB:`CSD_NEWSEL_LSB] = new_sel_r;
            rd_val[`CSD_SWREQ_BIT] = swreq_r;
         end
         `CSD_OFF_STATUS: rd_val = {20'h00000, cur_mode, 1'b0, swreq_r, pll_act,
                                    kind_r, cur_sel_r};
         default: rd_val = 32'h0000_0000; // unmapped reads as zero
      endcase
   end

   // bus phase tracking
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         dp_wr_r <= addr_ok & hwrite;
         dp_addr_r <= haddr[7:0];
         if (addr_ok & !hwrite) begin
            hrdata_r <= rd_val;
         end
      end
   end

   // divider and trim registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rc_postscale_sel_r <= `CSD_RCPS_RST;
         postscale_field_r <= `CSD_POST_RST;
         prescale_field_r <= `CSD_PRE_RST;
         feedback_field_r <= `CSD_FB_RST;
         tune_r <= `CSD_TUNE_RST;
      end else begin
         if (wr_div) begin
            rc_postscale_sel_r <= hwdata[`CSD_RCPS_MSB:`CSD_RCPS_LSB];
            postscale_field_r <= hwdata[`CSD_POST_MSB:`CSD_POST_LSB];
            prescale_field_r <= hwdata[`CSD_PRE_MSB:`CSD_PRE_LSB];
         end
         if (wr_fb) begin
            feedback_field_r <= hwdata[`CSD_FB_MSB:0];
         end
         if (wr_tune) begin
            tune_r <= hwdata[`CSD_TUNE_MSB:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock switch: the new source takes over only at an instruction period
   // boundary, so no shortened period reaches the core; a dead old source
   // therefore stalls the switch (no failsafe takeover here)
   assign sw_done = (sw_state_r == csd_pkg::CSD_SW_WAIT) & cy_boundary;
   // a software set in the clearing cycle wins
   assign swreq_nxt = (wr_ctrl & hwdata[`CSD_SWREQ_BIT]) | (swreq_r & ~sw_done);

   // sequencer next state
   always_comb begin
      sw_state_nxt = sw_state_r;
      cur_sel_nxt = cur_sel_r;
      case (sw_state_r)
         csd_pkg::CSD_SW_IDLE: begin
            if (swreq_r) begin
               sw_state_nxt = csd_pkg::CSD_SW_WAIT;
            end
         end
         csd_pkg::CSD_SW_WAIT: begin
            if (cy_boundary) begin
               cur_sel_nxt = eff_sel(new_sel_r, kind_r);
               sw_state_nxt = csd_pkg::CSD_SW_IDLE;
            end
         end
         default: sw_state_nxt = csd_pkg::CSD_SW_IDLE;
      endcase
   end

   // source state and configuration capture after reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_done_r <= 1'b0;
         kind_r <= 2'h0;
         new_sel_r <= 3'h0;
         swreq_r <= 1'b0;
         cur_sel_r <= csd_pkg::CSD_SEL_FAST_RC;
         sw_state_r <= csd_pkg::CSD_SW_IDLE;
      end else if (!cap_done_r) begin
         cap_done_r <= 1'b1;
         kind_r <= primary_osc_kind;
         new_sel_r <= initial_osc_sel;
         cur_sel_r <= eff_sel(initial_osc_sel, primary_osc_kind);
      end else begin
         if (wr_ctrl) begin
            new_sel_r <= hwdata[`CSD_NEWSEL_MSB:`CSD_NEWSEL_LSB];
         end
         swreq_r <= swreq_nxt;
         cur_sel_r <= cur_sel_nxt;
         sw_state_r <= sw_state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // divider chain
   csd_div_if rcps_if ();
   csd_div_if pre_if ();
   csd_div_if fb_if ();
   csd_div_if post_if ();
   csd_div_if cy_if ();
   logic pll_fin; // PLL input events
   logic osc_ev; // selected oscillator events

   assign rcps_if.in_tick = fast_rise;
   assign rcps_if.divisor = (cur_sel_r == csd_pkg::CSD_SEL_FAST_RC_DIV16) ?
                            `CSD_FIXED16_DIV : rc_post_div(rc_postscale_sel_r);
   assign pll_fin = (cur_sel_r == csd_pkg::CSD_SEL_PRIMARY_PLL) ? pri_rise : fast_rise;
   assign pre_if.in_tick = pll_fin & pll_act;
   assign pre_if.divisor = {5'h00, prescale_field_r} + `CSD_PLL_OFFSET;
   assign fb_if.in_tick = vco_rise & pll_act;
   assign fb_if.divisor = {1'b0, feedback_field_r} + `CSD_PLL_OFFSET;
   assign post_if.in_tick = vco_rise & pll_act;
   assign post_if.divisor = pll_post_div(postscale_field_r);

   // source multiplexer
   always_comb begin
      case (cur_sel_r)
         csd_pkg::CSD_SEL_FAST_RC: osc_ev = fast_rise;
         csd_pkg::CSD_SEL_FAST_RC_PLL: osc_ev = post_if.out_tick;
         csd_pkg::CSD_SEL_PRIMARY: osc_ev = pri_rise;
         csd_pkg::CSD_SEL_PRIMARY_PLL: osc_ev = post_if.out_tick;
         csd_pkg::CSD_SEL_SECONDARY: osc_ev = sec_rise;
         csd_pkg::CSD_SEL_SLOW_RC: osc_ev = slow_rise;
         default: osc_ev = rcps_if.out_tick;
      endcase
   end

   assign cy_if.in_tick = osc_ev;
   assign cy_if.divisor = `CSD_CY_DIV;
   assign cy_boundary = cy_if.out_tick;

   csd_clock_divisor_reg u_rcps (.clk(clk), .rst_n(rst_n), .dv(rcps_if));
   csd_clock_divisor_reg u_pre (.clk(clk), .rst_n(rst_n), .dv(pre_if));
   csd_clock_divisor_reg u_fb (.clk(clk), .rst_n(rst_n), .dv(fb_if));
   csd_clock_divisor_reg u_post (.clk(clk), .rst_n(rst_n), .dv(post_if));
   csd_clock_divisor_reg u_cy (.clk(clk), .rst_n(rst_n), .dv(cy_if));

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_tick <= 1'b0;
         instr_tick <= 1'b0;
         peripheral_timebase_tick <= 1'b0;
         watchdog_ref_tick <= 1'b0;
         failsafe_ref_tick <= 1'b0;
         pll_ref_tick <= 1'b0;
         pll_fb_tick <= 1'b0;
         pll_en <= 1'b0;
         primary_amp_en <= 1'b0;
         primary_high_gain <= 1'b0;
         rc_tune <= `CSD_TUNE_RST;
      end else begin
         osc_tick <= osc_ev;
         instr_tick <= cy_if.out_tick;
         peripheral_timebase_tick <= cy_if.out_tick;
         watchdog_ref_tick <= slow_rise;
         failsafe_ref_tick <= slow_rise;
         pll_ref_tick <= pre_if.out_tick;
         pll_fb_tick <= fb_if.out_tick;
         pll_en <= pll_act;
         // amplifier only for crystal kinds on a primary source
         primary_amp_en <= (cur_sel_r[2:1] == 2'b01) &
                           ((kind_r == csd_pkg::CSD_PRI_CRYSTAL) |
                            (kind_r == csd_pkg::CSD_PRI_HIGH_SPEED));
         primary_high_gain <= (cur_sel_r[2:1] == 2'b01) &
                              (kind_r == csd_pkg::CSD_PRI_HIGH_SPEED);
         rc_tune <= tune_r;
      end
   end

endmodule // csd_top
`default_nettype wire

// [test/csd_top_asserts.sv]
// Purpose: concurrent checks on the clock select top ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes: tick spacing bounds come from the 3-high 3-low pin minimum
`timescale 1ns/1ns
`default_nettype none
module csd_top_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic osc_tick,
   input wire logic instr_tick,
   input wire logic peripheral_timebase_tick,
   input wire logic watchdog_ref_tick,
   input wire logic failsafe_ref_tick,
   input wire logic pll_ref_tick,
   input wire logic pll_fb_tick,
   input wire logic pll_en,
   input wire logic primary_amp_en,
   input wire logic primary_high_gain
);
   ////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // zero-wait slave, never an error response
   bus_ready_a: assert property (hreadyout) else $error("hreadyout low");
   bus_okay_a: assert property (!hresp) else $error("hresp not okay");
   // both monitors share the slow rc events
   ref_pair_a: assert property (
      watchdog_ref_tick == failsafe_ref_tick) else $error("ref ticks differ");
   ref_spacing_a: assert property (
      watchdog_ref_tick |=> !watchdog_ref_tick [*5]) else $error("ref tick too close");
   timebase_same_a: assert property (
      instr_tick == peripheral_timebase_tick) else $error("timebase differs");
   instr_from_osc_a: assert property (
      instr_tick |-> osc_tick || $past(osc_tick)) else $error("instr without osc");
   // a runt would put two pulses closer than one pin period
   osc_spacing_a: assert property (
      osc_tick |=> !osc_tick [*4]) else $error("osc tick runt");
   pll_gate_a: assert property (
      !pll_en && !$past(pll_en) |-> !pll_ref_tick && !pll_fb_tick)
      else $error("pll tick while off");
   gain_amp_a: assert property (
      primary_high_gain |-> primary_amp_en) else $error("gain without amp");
endmodule // csd_top_asserts
bind csd_top csd_top_asserts i_csd_top_asserts (.clk, .rst_n, .hreadyout, .hresp,
   .osc_tick, .instr_tick, .peripheral_timebase_tick, .watchdog_ref_tick,
   .failsafe_ref_tick, .pll_ref_tick, .pll_fb_tick, .pll_en, .primary_amp_en,
   .primary_high_gain);
`default_nettype wire

// [test/csd_osc_model.sv]
// Purpose: free-running oscillator and vco pins
// Assumes: half periods are whole multiples of the 10 ns clk
// Notes: toggles fall on falling clk edges, between rising edges, so measured gaps are exact
`timescale 1ns/1ns
`default_nettype none
module csd_osc_model #(
   parameter int FAST_HALF = 30,
   parameter int PRI_HALF = 40,
   parameter int SEC_HALF = 50,
   parameter int SLOW_HALF = 60,
   parameter int VCO_HALF = 30
) (
   output var logic fast_rc_osc,
   output var logic primary_osc,
   output var logic secondary_osc,
   output var logic slow_rc_osc,
   output var logic vco_osc
);
   ////////////////////////////////////////////////////////////
   // oscillators run free
   initial {fast_rc_osc, primary_osc, secondary_osc, slow_rc_osc, vco_osc} = 5'h00;
   always #(FAST_HALF) fast_rc_osc = ~fast_rc_osc;
   always #(PRI_HALF) primary_osc = ~primary_osc;
   always #(SEC_HALF) secondary_osc = ~secondary_osc;
   always #(SLOW_HALF) slow_rc_osc = ~slow_rc_osc;
   always #(VCO_HALF) vco_osc = ~vco_osc;
endmodule // csd_osc_model
`default_nettype wire

// [test/test_csd.sv]
// Purpose: self-checking bench for the clock select block
// Assumes: pins from csd_osc_model, fast rc and vco period 6 clk, slow rc 12
// Notes: divider factors are checked as gaps between enable pulses
`timescale 1ns/1ns
`default_nettype none
`include "csd_regs.svh"
module test_system_clock_select_and_pll_divider;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, fr, po, so, sr, vc;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rnd = 32'h6a7b;
   logic [1:0] htrans = 0, kind = 0;
   logic [2:0] sel = 0, e;
   logic hreadyout, hresp, ot, it, wt, prt, pft, pen;
   logic [5:0] tune;
   int errors = 0, checks = 0, m;
   wire [5:0] watch = {hreadyout, pft, prt, wt, it, ot};
   csd_osc_model i_csd_osc_model (.fast_rc_osc(fr), .primary_osc(po), .secondary_osc(so),
      .slow_rc_osc(sr), .vco_osc(vc));
   csd_top i_csd_top (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .initial_osc_sel(sel),
      .primary_osc_kind(kind), .fast_rc_osc(fr), .primary_osc(po), .secondary_osc(so),
      .slow_rc_osc(sr), .vco_osc(vc), .osc_tick(ot), .instr_tick(it),
      .peripheral_timebase_tick(), .watchdog_ref_tick(wt), .failsafe_ref_tick(),
      .pll_ref_tick(prt), .pll_fb_tick(pft), .pll_en(pen), .primary_amp_en(),
      .primary_high_gain(), .rc_tune(tune));
   initial forever #5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // primary with kind 11 falls back to fast rc
   function automatic logic [2:0] exp_src(input logic [2:0] s, input logic [1:0] k);
      return (s[2:1] == 2'h1 && k == 2'h3) ? 3'h0 : s;
   endfunction
   function automatic logic [3:0] exp_mode(input logic [2:0] s, input logic [1:0] k);
      logic [3:0] x;
      x = {1'b0, exp_src(s, k)};
      if (x[2]) return 4'h7 - x;
      if (x[1]) return (x[0] ? 4'h6 : 4'h9) - {2'h0, k};
      return 4'hB - x;
   endfunction
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, g);
      checks++;
      if (g !== x) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask
   // bounded wait on a watched bit
   task automatic wait_on(input int b, input int lim);
      m = 0;
      do begin
         @(posedge clk);
         m++;
      end while (watch[b] !== 1'b1 && m < lim);
      if (m >= lim) begin
         errors++;
         final_report();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_on(5, 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_on(5, 50);
      rd = hrdata;
   endtask
   // the third gap is past the old factor's last period
   task automatic gap(input int b, input int x);
      repeat (3) wait_on(b, 4000);
      chk("tick gap", x, m);
   endtask
   task automatic reset_to(input logic [2:0] s, input logic [1:0] k);
      rst_n <= 1'b0;
      sel <= s;
      kind <= k;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 12; i++) begin
         rnd = lfsr(rnd);
         reset_to(i[2:0], (i > 9) ? 2'h3 : rnd[1:0]);
         e = exp_src(sel, kind);
         bus(1'b0, `CSD_OFF_STATUS, 32'h0);
         chk("status", {exp_mode(sel, kind), {2{e[0] & ~e[2]}}, kind, e},
             {rd[11:8], pen, rd[5:0]});
      end
      reset_to(3'h7, 2'h0);
      bus(1'b0, `CSD_OFF_DIVISOR, 32'h0);
      chk("divisor", 32'h40, rd);
      bus(1'b1, 8'h14, 32'hFFFF);
      bus(1'b0, 8'h14, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b1, `CSD_OFF_TUNE, {26'h0, rnd[5:0]});
      bus(1'b0, `CSD_OFF_TUNE, 32'h0);
      chk("tune", {26'h0, rnd[5:0]}, rd);
      chk("rc_tune", rnd[5:0], tune);
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, `CSD_OFF_DIVISOR, {21'h0, c[2:0], 8'h40});
         gap(0, 6 * ((c == 7) ? 256 : (1 << c)));
      end
      bus(1'b1, `CSD_OFF_DIVISOR, 32'h40);
      gap(1, 12);
      gap(2, 12);
      reset_to(3'h1, 2'h0);
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, `CSD_OFF_DIVISOR, {24'h0, p[1:0], 6'h1F});
         gap(0, 6 * ((p == 3) ? 8 : (p == 0) ? 2 : 4));
      end
      gap(3, 6 * 33);
      bus(1'b1, `CSD_OFF_DIVISOR, 32'h0);
      gap(3, 12);
      bus(1'b1, `CSD_OFF_FEEDBACK, 32'h1E);
      gap(4, 6 * 32);
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, `CSD_OFF_CTRL, j ? 32'h301 : 32'h1);
         for (int w = 0; w < 60 && (w == 0 || rd[6] !== 1'b0); w++)
            bus(1'b0, `CSD_OFF_STATUS, 32'h0);
         chk("switched", j ? 3'h3 : 3'h0, rd[2:0]);
      end
      final_report();
   end
endmodule // test_system_clock_select_and_pll_divider
`default_nettype wire
